// file: core/exc_monitor.sv
// Interrupt acknowledge arbitration, spurious and bus monitors,
// double bus fault detection, halt output and halt monitor reset.
// Assumes one clock, async active-low reset, AXI4-Lite from software.
// Contract
// - Each source has its own arbitration value; external uses config field; zero never arbitrates.
// - Acknowledge ended by bus error yields spurious vector 24.
// - No source arbitrating in an acknowledge raises internal bus error.
// - Winner not terminating the acknowledge raises bus error via the bus monitor.
// - External bus error during acknowledge makes the interrupt spurious.
// - Requests at or below the priority mask are ignored.
// - Internal requester answers acknowledge with internal data-size acknowledge.
// - Second bus error during bus error processing is a double fault.
// - Bus error before first instruction after reset is a double fault.
// - Bus error during return-from-exception frame reload is a double fault.
// - Double fault drives halt low and stops until reset.
// - Halt with halt monitor enabled generates reset at once.
// - Halt monitor disabled keeps the device halted until external reset.
// - External bus error pulse ends a hung cycle.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module exc_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt sources: source 0 is external, others internal modules
  input wire logic [exc_monitor_pkg::NUM_INT-1:0] intReq,
  input wire logic [exc_monitor_pkg::NUM_INT*exc_monitor_pkg::LVL_W-1:0] intLevel,
  input wire logic [exc_monitor_pkg::NUM_INT*exc_monitor_pkg::ARB_W-1:0] modArb,
  // Acknowledge terminations from sources
  input wire logic dataSizeAck,
  input wire logic autovectorReq,
  input wire logic busErrorIn,
  // Processor status
  input wire logic firstInstrDone,
  input wire logic berrProcessing,
  input wire logic rteFrameLoad,
  // Acknowledge cycle outputs
  output logic ackCycle,
  output logic [exc_monitor_pkg::LVL_W-1:0] ackLevel,
  output logic [1:0] ackWinner,
  output logic vectorValid,
  output logic [7:0] vectorNum,
  // Faults and reset
  output logic busErrorInt,
  output logic haltOut_n,
  output logic haltOutEn,
  output logic resetReq,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [exc_monitor_pkg::ARB_W-1:0] extArb;
  logic [exc_monitor_pkg::LVL_W-1:0] prioMask;
  logic haltMonEn;
  logic [exc_monitor_pkg::ST_W-1:0] status;
  logic [exc_monitor_pkg::ST_W-1:0] mask;
  logic [exc_monitor_pkg::ST_W-1:0] evt;
  exc_monitor_pkg::ack_state_t state;
  logic [exc_monitor_pkg::TMR_W-1:0] timer;
  logic [4:0] rstCnt;
  logic bootPhase;
  logic haltCause;
  logic [7:0] lastVector;

  // ----------------------------------------------------------------
  // Request filtering and arbitration
  // ----------------------------------------------------------------
  logic [exc_monitor_pkg::NUM_INT-1:0] valid;
  logic [exc_monitor_pkg::NUM_INT-1:0] atLevel;
  logic [exc_monitor_pkg::NUM_INT*exc_monitor_pkg::ARB_W-1:0] arbFlat;
  logic [exc_monitor_pkg::LVL_W-1:0] topLevel;
  logic anyValid;
  logic found;
  logic [1:0] winner;

  // Per source: arbitration value and level masking
  genvar g;
  generate
    for (g = 0; g < exc_monitor_pkg::NUM_INT; g++) begin : gSrc
      if (g == 0) begin : gExt
        assign arbFlat[0 +: exc_monitor_pkg::ARB_W] = extArb;
      end else begin : gMod
        assign arbFlat[g*exc_monitor_pkg::ARB_W +: exc_monitor_pkg::ARB_W] =
          modArb[g*exc_monitor_pkg::ARB_W +: exc_monitor_pkg::ARB_W];
      end
      assign valid[g] = intReq[g] &&
        intLevel[g*exc_monitor_pkg::LVL_W +: exc_monitor_pkg::LVL_W] > prioMask;
      assign atLevel[g] = valid[g] &&
        intLevel[g*exc_monitor_pkg::LVL_W +: exc_monitor_pkg::LVL_W] == topLevel;
    end
  endgenerate

  // Highest pending level
  always_comb begin
    topLevel = '0;
    for (int i = 0; i < exc_monitor_pkg::NUM_INT; i++) begin
      if (valid[i] &&
          intLevel[i*exc_monitor_pkg::LVL_W +: exc_monitor_pkg::LVL_W] > topLevel) begin
        topLevel = intLevel[i*exc_monitor_pkg::LVL_W +: exc_monitor_pkg::LVL_W];
      end
    end
  end
  assign anyValid = |valid;

  // Picks the highest arbitration value at the acknowledged level
  arb_pick uPick (
    .cand(atLevel),
    .arbFlat(arbFlat),
    .found(found),
    .winner(winner)
  );

  // ----------------------------------------------------------------
  // Acknowledge sequencer
  // ----------------------------------------------------------------
  logic faultNow;
  logic doubleFault;
  assign faultNow = busErrorIn || busErrorInt;
  assign doubleFault = faultNow && (berrProcessing || !bootPhase || rteFrameLoad);

  // Acknowledge cycle flow with monitors
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= exc_monitor_pkg::S_IDLE;
      ackCycle <= 1'b0;
      ackLevel <= '0;
      ackWinner <= 2'd0;
      vectorValid <= 1'b0;
      vectorNum <= 8'h00;
      busErrorInt <= 1'b0;
      timer <= '0;
      evt <= '0;
    end else begin
      evt <= '0;
      vectorValid <= 1'b0;
      busErrorInt <= 1'b0;
      case (state)
        exc_monitor_pkg::S_IDLE: begin
          if (anyValid && bootPhase) begin
            state <= exc_monitor_pkg::S_ARB;
            ackCycle <= 1'b1;
            ackLevel <= topLevel;
          end
        end
        exc_monitor_pkg::S_ARB: begin
          timer <= '0;
          if (busErrorIn) begin
            state <= exc_monitor_pkg::S_DONE;
            vectorValid <= 1'b1;
            vectorNum <= exc_monitor_pkg::SPURIOUS_VECTOR;
            evt[exc_monitor_pkg::ST_EXT_BUS_ERROR_SIGNAL] <= 1'b1;
            evt[exc_monitor_pkg::ST_SPURIOUS] <= 1'b1;
          end else if (!found) begin
            state <= exc_monitor_pkg::S_DONE;
            busErrorInt <= 1'b1;
            vectorValid <= 1'b1;
            vectorNum <= exc_monitor_pkg::SPURIOUS_VECTOR;
            evt[exc_monitor_pkg::ST_NO_ARB] <= 1'b1;
            evt[exc_monitor_pkg::ST_SPURIOUS] <= 1'b1;
          end else begin
            state <= exc_monitor_pkg::S_WAIT;
            ackWinner <= winner;
          end
        end
        exc_monitor_pkg::S_WAIT: begin
          timer <= timer + 1'b1;
          if (busErrorIn) begin
            state <= exc_monitor_pkg::S_DONE;
            vectorValid <= 1'b1;
            vectorNum <= exc_monitor_pkg::SPURIOUS_VECTOR;
            evt[exc_monitor_pkg::ST_EXT_BUS_ERROR_SIGNAL] <= 1'b1;
            evt[exc_monitor_pkg::ST_SPURIOUS] <= 1'b1;
          end else if (dataSizeAck) begin
            state <= exc_monitor_pkg::S_DONE;
            vectorValid <= 1'b1;
            vectorNum <= {4'h4, 2'b00, ackWinner};
          end else if (autovectorReq) begin
            state <= exc_monitor_pkg::S_DONE;
            vectorValid <= 1'b1;
            vectorNum <= exc_monitor_pkg::AUTOVECTOR_BASE + 8'(ackLevel);
          end else if (timer == 8'(exc_monitor_pkg::BUS_TIMEOUT_CYC - 1)) begin
            state <= exc_monitor_pkg::S_DONE;
            busErrorInt <= 1'b1;
            vectorValid <= 1'b1;
            vectorNum <= exc_monitor_pkg::SPURIOUS_VECTOR;
            evt[exc_monitor_pkg::ST_NO_TERM] <= 1'b1;
            evt[exc_monitor_pkg::ST_SPURIOUS] <= 1'b1;
          end
        end
        exc_monitor_pkg::S_DONE: begin
          ackCycle <= 1'b0;
          state <= exc_monitor_pkg::S_IDLE;
        end
        exc_monitor_pkg::S_HALT: begin
          ackCycle <= 1'b0;
        end
        default: begin
          state <= exc_monitor_pkg::S_IDLE;
        end
      endcase
      if (doubleFault) begin
        state <= exc_monitor_pkg::S_HALT;
        evt[exc_monitor_pkg::ST_DOUBLE] <= 1'b1;
      end
      if (state == exc_monitor_pkg::S_HALT) begin
        state <= exc_monitor_pkg::S_HALT;
        vectorValid <= 1'b0;
        busErrorInt <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Boot phase, halt output and halt monitor reset
  // ----------------------------------------------------------------
  // Boot phase ends when the first instruction has executed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootPhase <= 1'b0;
    end else if (firstInstrDone) begin
      bootPhase <= 1'b1;
    end
  end

  // Halt line held low from the double fault until reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      haltOut_n <= 1'b1;
      haltOutEn <= 1'b0;
      haltCause <= 1'b0;
    end else if (doubleFault && state != exc_monitor_pkg::S_HALT) begin
      haltOut_n <= 1'b0;
      haltOutEn <= 1'b1;
      haltCause <= 1'b1;
    end
  end

  // Reset request raised and held until reset when halted with the halt monitor enabled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resetReq <= 1'b0;
      rstCnt <= '0;
    end else if (haltCause && haltMonEn && !resetReq && rstCnt == '0) begin
      resetReq <= 1'b1;
      rstCnt <= 5'(exc_monitor_pkg::HALT_RST_CYC - 1);
    end else if (rstCnt != '0) begin
      rstCnt <= rstCnt - 1'b1;
    end else begin
      resetReq <= resetReq;
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  logic wrFire;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic awHeld;
  logic wHeld;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      for (int i = 0; i < exc_monitor_pkg::ST_W; i++) begin
        if (evt[i] || (i == exc_monitor_pkg::ST_HALT_RESET && resetReq && rstCnt ==
            5'(exc_monitor_pkg::HALT_RST_CYC - 1))) begin
          status[i] <= 1'b1;
        end else if (wrFire && wrAddr == exc_monitor_pkg::OFS_STATUS && wrData[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Last delivered vector kept for software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lastVector <= 8'h00;
    end else if (vectorValid) begin
      lastVector <= vectorNum;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are taken in either order, then answered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrAddr <= exc_monitor_pkg::OFS_STATE && wrAddr[1:0] == 2'b00) ?
          2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
    end
  end

  // Writable registers; only strobe bit 0 is checked for these narrow fields
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      extArb <= exc_monitor_pkg::RST_CONFIG[exc_monitor_pkg::CFG_EXT_ARB_LSB +: 4];
      prioMask <= exc_monitor_pkg::RST_CONFIG[exc_monitor_pkg::CFG_PRIO_MASK_LSB +: 3];
      haltMonEn <= exc_monitor_pkg::HME_RESET;
      mask <= '0;
    end else if (wrFire && s_axi_wstrb[0]) begin
      case (wrAddr)
        exc_monitor_pkg::OFS_CONFIG: begin
          extArb <= wrData[exc_monitor_pkg::CFG_EXT_ARB_LSB +: 4];
          prioMask <= wrData[exc_monitor_pkg::CFG_PRIO_MASK_LSB +: 3];
        end
        exc_monitor_pkg::OFS_PROTECT: begin
          haltMonEn <= wrData[exc_monitor_pkg::PROT_HME_BIT];
        end
        exc_monitor_pkg::OFS_MASK: begin
          mask <= wrData[exc_monitor_pkg::ST_W-1:0];
        end
        default: begin
          mask <= mask;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // One read at a time, data registered with the answer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          exc_monitor_pkg::OFS_CONFIG: s_axi_rdata <= {25'h0, prioMask, extArb};
          exc_monitor_pkg::OFS_PROTECT: s_axi_rdata <= {31'h0, haltMonEn};
          exc_monitor_pkg::OFS_STATUS: s_axi_rdata <= {26'h0, status};
          exc_monitor_pkg::OFS_MASK: s_axi_rdata <= {26'h0, mask};
          exc_monitor_pkg::OFS_VECTOR: s_axi_rdata <= {24'h0, lastVector};
          exc_monitor_pkg::OFS_STATE: s_axi_rdata <= {24'h0, bootPhase, ackCycle,
            ackWinner, ackLevel, !haltOut_n};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : exc_monitor
`default_nettype wire

// file: core/exc_monitor_pkg.sv
// Package for the interrupt acknowledge and bus-fault monitor.
// Assumes a single 100 MHz clock and AXI4-Lite register access.
package exc_monitor_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_VECTOR = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  // Field positions and sizes
  localparam int NUM_INT = 4;
  localparam int ARB_W = 4;
  localparam int LVL_W = 3;
  localparam int CFG_EXT_ARB_LSB = 0;
  localparam int CFG_PRIO_MASK_LSB = 4;
  localparam int PROT_HME_BIT = 0;
  // Status bit positions
  localparam int ST_SPURIOUS = 0;
  localparam int ST_NO_ARB = 1;
  localparam int ST_NO_TERM = 2;
  localparam int ST_EXT_BUS_ERROR_SIGNAL = 3;
  localparam int ST_DOUBLE = 4;
  localparam int ST_HALT_RESET = 5;
  localparam int ST_W = 6;
  // Reset values
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic HME_RESET = 1'b1;
  // Vectors
  localparam logic [7:0] SPURIOUS_VECTOR = 8'd24;
  localparam logic [7:0] AUTOVECTOR_BASE = 8'd24;
  // Bus monitor timeout: 640 ns at 10 ns per cycle
  localparam int BUS_TIMEOUT_NS = 640;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  // Countdown loaded when the halt monitor raises its reset request; the request stays high until reset
  localparam int HALT_RST_CYC = 16;
  // Acknowledge sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ARB = 5'b00010,
    S_WAIT = 5'b00100,
    S_DONE = 5'b01000,
    S_HALT = 5'b10000
  } ack_state_t;
endpackage : exc_monitor_pkg

// file: core/arb_pick.sv
// Priority picker for the acknowledge arbitration.
// Assumes requests already filtered by level; combinational only.
`timescale 1ns/1ps
`default_nettype none
module arb_pick (
  // Candidates
  input wire logic [exc_monitor_pkg::NUM_INT-1:0] cand,
  input wire logic [exc_monitor_pkg::NUM_INT*exc_monitor_pkg::ARB_W-1:0] arbFlat,
  // Result
  output logic found,
  output logic [1:0] winner
);
  logic [exc_monitor_pkg::ARB_W-1:0] best;
  // Highest non-zero arbitration value wins
  always_comb begin
    found = 1'b0;
    winner = 2'd0;
    best = '0;
    for (int i = 0; i < exc_monitor_pkg::NUM_INT; i++) begin
      if (cand[i] && arbFlat[i*exc_monitor_pkg::ARB_W +: exc_monitor_pkg::ARB_W] != '0 &&
          arbFlat[i*exc_monitor_pkg::ARB_W +: exc_monitor_pkg::ARB_W] > best) begin
        found = 1'b1;
        winner = i[1:0];
        best = arbFlat[i*exc_monitor_pkg::ARB_W +: exc_monitor_pkg::ARB_W];
      end
    end
  end
endmodule : arb_pick
`default_nettype wire

// file: tb/irq_source_model.sv
// Model of the interrupt sources and slaves.
// Assumes the bench pulses raise for one cycle per new request.
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bench control
  input wire logic [3:0] raise,
  input wire logic [11:0] lvl,
  input wire logic [15:0] arb,
  input wire logic [1:0] termSel,
  input wire logic berrPulse,
  // Monitor side
  input wire logic ackCycle,
  input wire logic vectorValid,
  output logic [3:0] intReq,
  output logic [11:0] intLevel,
  output logic [15:0] modArb,
  output logic dataSizeAck,
  output logic autovectorReq,
  output logic busErrorIn
);
  logic [2:0] waitCnt;
  logic term;
  // Requests stay latched until the acknowledge delivers a vector
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      intReq <= '0;
    end else if (vectorValid) begin
      intReq <= '0;
    end else begin
      intReq <= intReq | raise;
    end
  end
  // Counts acknowledge cycles before the slave answers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waitCnt <= '0;
    end else if (!ackCycle) begin
      waitCnt <= '0;
    end else if (waitCnt != 3'd7) begin
      waitCnt <= waitCnt + 3'd1;
    end
  end
  // Termination held until the acknowledge closes; code 3 stays silent
  assign intLevel = lvl;
  assign modArb = arb;
  assign term = ackCycle && (waitCnt >= 3'd3);
  assign dataSizeAck = term && (termSel == 2'd0);
  assign autovectorReq = term && (termSel == 2'd1);
  assign busErrorIn = (term && (termSel == 2'd2)) || berrPulse;
endmodule : irq_source_model
`default_nettype wire

// file: tb/exc_monitor_assertions.sv
// Port checker for the bus-fault monitor.
// Assumes one clock domain; bound onto exc_monitor below.
`timescale 1ns/1ps
`default_nettype none
module exc_monitor_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Watched inputs
  input wire logic dataSizeAck,
  input wire logic autovectorReq,
  input wire logic busErrorIn,
  input wire logic firstInstrDone,
  input wire logic berrProcessing,
  input wire logic rteFrameLoad,
  // Watched outputs
  input wire logic ackCycle,
  input wire logic [exc_monitor_pkg::LVL_W-1:0] ackLevel,
  input wire logic [1:0] ackWinner,
  input wire logic vectorValid,
  input wire logic [7:0] vectorNum,
  input wire logic haltOut_n,
  input wire logic haltOutEn,
  input wire logic resetReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic bootDone;
  // Remembers that the first instruction has run
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootDone <= 1'b0;
    end else if (firstInstrDone) begin
      bootDone <= 1'b1;
    end
  end
  // Acknowledge past arbitration and still open
  sequence s_open_ack;
    ackCycle && !vectorValid && $past(ackCycle, 2);
  endsequence
  sequence s_spurious_vec;
    ##[1:4] (vectorValid && (vectorNum == 8'h18));
  endsequence
  AST_SPUR_BUS_ERROR_SIGNAL: assert property ($rose(busErrorIn) && ackCycle |-> s_spurious_vec)
    else $error("no spurious vector");
  AST_DATA_SIZE_ACKNOWLEDGE_VEC: assert property (s_open_ack ##0 dataSizeAck
    |=> vectorValid && (vectorNum == (8'h40 | 8'(ackWinner))))
    else $error("bad ack vector");
  AST_AUTOVECTOR_REQUEST_VEC: assert property (s_open_ack ##0 autovectorReq
    |=> vectorValid && (vectorNum == (8'h18 + 8'(ackLevel))))
    else $error("bad autovector");
  AST_ACK_BOUND: assert property ($rose(ackCycle) |-> ##[1:80] !ackCycle)
    else $error("ack hung");
  AST_HALT_STICKY: assert property (!haltOut_n |=> !haltOut_n)
    else $error("halt released");
  AST_HALT_DRIVE: assert property ($fell(haltOut_n) |-> haltOutEn ##1 haltOutEn[*8])
    else $error("halt not driven");
  AST_DBL_BUS_ERROR_SIGNAL: assert property (busErrorIn && berrProcessing |=> !haltOut_n)
    else $error("no halt on bus_error_signal");
  AST_DBL_RTE: assert property (busErrorIn && rteFrameLoad |=> !haltOut_n)
    else $error("no halt on reload");
  AST_DBL_BOOT: assert property (busErrorIn && !bootDone && !firstInstrDone |=> !haltOut_n)
    else $error("no halt at boot");
  AST_RST_REQ: assert property ($rose(resetReq) |-> !haltOut_n ##0 resetReq[*8])
    else $error("bad reset request");
endmodule : exc_monitor_assertions
bind exc_monitor exc_monitor_assertions exc_monitor_assertions_i (.core_clk, .resetn,
  .dataSizeAck, .autovectorReq, .busErrorIn, .firstInstrDone, .berrProcessing,
  .rteFrameLoad, .ackCycle, .ackLevel, .ackWinner, .vectorValid, .vectorNum,
  .haltOut_n, .haltOutEn, .resetReq);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the bus-fault monitor.
// Assumes the source model answers acknowledges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, berrPulse = 1'b0;
  logic firstInstrDone = 1'b0, berrProcessing = 1'b0, rteFrameLoad = 1'b0;
  logic [3:0] raise = '0;
  logic [11:0] lvl = '0;
  logic [15:0] arb = '0;
  logic [1:0] termSel = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ackWinner;
  logic [31:0] s_axi_rdata;
  logic [3:0] intReq;
  logic [11:0] intLevel;
  logic [15:0] modArb;
  logic [2:0] ackLevel;
  logic [7:0] vectorNum;
  logic dataSizeAck, autovectorReq, busErrorIn, ackCycle, vectorValid;
  logic busErrorInt, haltOut_n, haltOutEn, resetReq, irq;
  int n_fail = 0;
  int cmp_count = 0;
  logic [33:0] rdQ[$];
  logic [33:0] rx;
  logic [7:0] vq[$];
  logic [3:0] rnd;
  // Clock at 100 MHz
  always #5 core_clk = ~core_clk;
  exc_monitor exc_monitor_i (.*);
  irq_source_model irq_source_model_i (.*);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic doReset;
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
  endtask : doReset
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w || !s_axi_bvalid) begin
      tick(1);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    check("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    tick(1);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    rdQ.push_back({er, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (ar || !s_axi_rvalid) begin
      tick(1);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    tick(1);
  endtask : axr
  task automatic pulse(input logic boot);
    firstInstrDone <= boot;
    berrPulse <= !boot;
    tick(1);
    firstInstrDone <= 1'b0;
    berrPulse <= 1'b0;
  endtask : pulse
  task automatic src(input logic [3:0] r, input logic [11:0] l, input logic [15:0] a,
                     input logic [1:0] ts);
    lvl <= l;
    arb <= a;
    termSel <= ts;
    raise <= r;
    tick(1);
    raise <= '0;
  endtask : src
  task automatic ackRun(input logic [3:0] r, input logic [11:0] l, input logic [15:0] a,
                        input logic [1:0] ts, input logic [7:0] v);
    vq.push_back(v);
    src(r, l, a, ts);
    while (vq.size() != 0) tick(1);
    tick(3);
  endtask : ackRun
  // Compares each vector and read answer with the oldest note
  always @(posedge core_clk) begin
    if (vectorValid === 1'b1) begin
      check("vector", vectorNum, vq.size() != 0 ? vq.pop_front() : 8'hff);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready && rdQ.size() != 0) begin
      rx = rdQ.pop_front();
      check("rdata", s_axi_rdata, rx[31:0]);
      check("rresp", s_axi_rresp, rx[33:32]);
    end
  end
  // Watchdog
  initial begin
    tick(6000);
    n_fail++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hc284b23a));
    doReset();
    axr(8'h04, 32'h1, 2'b00);
    axr(8'h00, 32'h0, 2'b00);
    axr(8'h18, 32'h0, 2'b10);
    axw(8'h1c, 32'h1, 2'b10);
    axw(8'h00, 32'h31, 2'b00);
    axw(8'h0c, 32'h0, 2'b00);
    pulse(1'b1);
    rnd = 4'($urandom_range(15, 5));
    ackRun(4'b1100, 12'hb40, {rnd, 4'h4, 8'h00}, 2'd0, 8'h43);
    ackRun(4'b0010, 12'h020, 16'h0020, 2'd1, 8'h1c);
    src(4'b0010, 12'h018, 16'h0020, 2'd1);
    tick(10);
    check("ackCycle", ackCycle, 1'b0);
    vq.push_back(8'h1b);
    axw(8'h00, 32'h21, 2'b00);
    tick(15);
    ackRun(4'b0100, 12'h180, 16'h0000, 2'd3, 8'h18);
    ackRun(4'b0001, 12'h007, 16'h0000, 2'd2, 8'h18);
    ackRun(4'b1000, 12'hc00, 16'h5000, 2'd3, 8'h18);
    axr(8'h08, 32'h0f, 2'b00);
    check("irq", irq, 1'b0);
    axw(8'h0c, 32'h3f, 2'b00);
    tick(3);
    check("irq", irq, 1'b1);
    axw(8'h08, 32'h0f, 2'b00);
    tick(3);
    check("irq", irq, 1'b0);
    axr(8'h08, 32'h0, 2'b00);
    berrProcessing <= 1'b1;
    pulse(1'b0);
    tick(3);
    berrProcessing <= 1'b0;
    check("halt", haltOut_n, 1'b0);
    check("haltEn", haltOutEn, 1'b1);
    check("resetReq", resetReq, 1'b1);
    axr(8'h08, 32'h30, 2'b00);
    doReset();
    check("halt", haltOut_n, 1'b1);
    axw(8'h04, 32'h0, 2'b00);
    pulse(1'b1);
    rteFrameLoad <= 1'b1;
    pulse(1'b0);
    rteFrameLoad <= 1'b0;
    tick(20);
    check("halt", haltOut_n, 1'b0);
    check("resetReq", resetReq, 1'b0);
    doReset();
    pulse(1'b0);
    tick(3);
    check("halt", haltOut_n, 1'b0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
